/* rtl/serial_cfg_pkg.sv */
// Constants for the serial port configuration block: register map,
// reset values, selection codes and bit rates.
// Assumes a 16-bit holding register access port and one 200 MHz clock.
package serial_cfg_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int CLK_HZ_DEF = 200_000_000;   // Core clock rate in Hz

  // ==========================================================================
  // Register offsets (holding register numbers)
  // ==========================================================================
  localparam logic [15:0] OFS_COMMAND          = 16'h0001;
  localparam logic [15:0] OFS_DP_RATE_SELECT   = 16'h0005;
  localparam logic [15:0] OFS_DP_PARITY_SELECT = 16'h0006;
  localparam logic [15:0] OFS_DP_RATE_STATUS   = 16'h0007;
  localparam logic [15:0] OFS_CP_RATE_SELECT   = 16'h0012;
  localparam logic [15:0] OFS_CP_FRAME_FORMAT  = 16'h0013;
  localparam logic [15:0] OFS_CP_RATE_STATUS   = 16'h0014;
  localparam logic [15:0] OFS_CP_FORMAT_STATUS = 16'h0015;

  // ==========================================================================
  // Reset values and command codes
  // ==========================================================================
  localparam logic [15:0] RST_COMMAND          = 16'h0000;
  localparam logic [15:0] RST_DP_RATE_SELECT   = 16'h0000;
  localparam logic [15:0] RST_DP_PARITY_SELECT = 16'h0000;
  localparam logic [15:0] RST_CP_RATE_SELECT   = 16'h0007;
  localparam logic [15:0] RST_CP_FRAME_FORMAT  = 16'h0001;
  localparam logic [15:0] CMD_MODULE_RESET     = 16'h0003;

  // ==========================================================================
  // Rate codes
  // ==========================================================================
  localparam logic [2:0] RATE_AUTO    = 3'h0;   // Auto detect / unknown
  localparam logic [2:0] RATE_FIRST   = 3'h1;   // 2400 bit/s
  localparam logic [2:0] RATE_LAST    = 3'h7;   // 115200 bit/s
  localparam logic [2:0] RATE_DEFAULT = 3'h7;   // Fallback rate

  localparam int BAUD_2400   = 2400;
  localparam int BAUD_4800   = 4800;
  localparam int BAUD_9600   = 9600;
  localparam int BAUD_19200  = 19200;
  localparam int BAUD_38400  = 38400;
  localparam int BAUD_57600  = 57600;
  localparam int BAUD_115200 = 115200;

  // ==========================================================================
  // Data port parity codes and config port format field
  // ==========================================================================
  localparam logic [15:0] DP_PAR_EVEN = 16'h0000;
  localparam logic [15:0] DP_PAR_ODD  = 16'h0001;
  localparam logic [15:0] DP_PAR_NONE = 16'h0002;

  localparam int FMT_PARITY_ENABLE_BIT  = 0;
  localparam int FMT_ODD_PARITY_BIT     = 1;
  localparam int FMT_TWO_STOP_BITS_BIT  = 2;
  localparam logic [2:0] FMT_DEFAULT    = 3'h1;   // Even parity, 1 stop
  localparam logic [15:0] FMT_MAX       = 16'h0007;

endpackage

/* rtl/rate_tick_if.sv */
// Carrier between the configuration logic and a bit rate tick generator.
// Assumes both ends share core_clk_in.
`timescale 1ns/1ps
interface rate_tick_if;
  logic [2:0] rate_code;   // Rate code 1..7, 0 stops the tick
  logic       tick;        // One-cycle bit period pulse

  modport gen  (input rate_code, output tick);
  modport user (output rate_code, input tick);
endinterface

/* rtl/baud_tick_gen.sv */
// Bit rate tick generator: one-cycle pulse every bit period.
// Assumes the rate code is held stable while a port is running.
`timescale 1ns/1ps
module baud_tick_gen #(
  parameter int CLK_HZ = serial_cfg_pkg::CLK_HZ_DEF
) (
  input  wire logic     core_clk_in,   // Core clock
  input  wire logic     reset_n_in,    // Async reset, active low
  rate_tick_if.gen      tk             // Rate code in, tick out
);

  logic [16:0] divisor;
  logic [16:0] count_ff;
  logic [2:0]  code_ff;
  logic        tick_ff;

  // ==========================================================================
  // Divisor lookup
  // ==========================================================================
  // Period in core cycles for the selected rate
  always_comb begin
    unique case (tk.rate_code)
      3'h1:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_2400);
      3'h2:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_4800);
      3'h3:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_9600);
      3'h4:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_19200);
      3'h5:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_38400);
      3'h6:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_57600);
      3'h7:    divisor = 17'(CLK_HZ / serial_cfg_pkg::BAUD_115200);
      default: divisor = 17'h0_0000;
    endcase
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Restart on a code change so a new rate never inherits a stale phase
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_ff <= 17'h0_0000;
      code_ff  <= 3'h0;
      tick_ff  <= 1'b0;
    end else begin
      code_ff <= tk.rate_code;
      if (tk.rate_code != code_ff || divisor == 17'h0_0000) begin
        count_ff <= 17'h0_0000;
        tick_ff  <= 1'b0;
      end else if (count_ff >= divisor - 17'h0_0001) begin
        count_ff <= 17'h0_0000;
        tick_ff  <= 1'b1;
      end else begin
        count_ff <= count_ff + 17'h0_0001;
        tick_ff  <= 1'b0;
      end
    end
  end

  assign tk.tick = tick_ff;

endmodule

/* rtl/serial_port_config.sv */
// Configuration and status of the fieldbus data port and the config port.
// Assumes a holding register port synchronous to core_clk_in and a frame
// decoder that reports good and bad frames on the data port.
`timescale 1ns/1ps
module serial_port_config #(
  parameter int CLK_HZ = serial_cfg_pkg::CLK_HZ_DEF
) (
  input  wire logic        core_clk_in,         // Core clock, 200 MHz
  input  wire logic        reset_n_in,          // Async reset, active low
  input  wire logic        reg_wr_in,           // Register write strobe
  input  wire logic        reg_rd_in,           // Register read strobe
  input  wire logic [15:0] reg_addr_in,         // Register number
  input  wire logic [15:0] reg_wdata_in,        // Write data
  output logic      [15:0] reg_rdata_out,       // Read data, next cycle
  input  wire logic        dp_frame_ok_in,      // Good frame seen, pulse
  input  wire logic        dp_frame_bad_in,     // Bad frame seen, pulse
  output logic             dp_bit_tick_out,     // Data port bit tick
  output logic             dp_parity_en_out,    // Data port parity on
  output logic             dp_odd_parity_out,   // Data port odd parity
  output logic             dp_two_stop_out,     // Data port two stop bits
  output logic             dp_reply_en_out,     // Replies allowed
  output logic             cp_bit_tick_out,     // Config port bit tick
  output logic             cp_parity_en_out,    // Config port parity on
  output logic             cp_odd_parity_out,   // Config port odd parity
  output logic             cp_two_stop_out      // Config port two stop bits
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [15:0] cmd_ff;
  logic [15:0] dp_rate_sel_ff;
  logic [15:0] dp_par_sel_ff;
  logic [15:0] cp_rate_sel_ff;
  logic [15:0] cp_fmt_sel_ff;
  logic        apply_pend_ff;
  logic        apply;
  logic [2:0]  dp_rate_ff;
  logic        dp_auto_ff;
  logic        dp_locked_ff;
  logic        dp_par_en_ff;
  logic        dp_odd_ff;
  logic        dp_two_stop_ff;
  logic [2:0]  cp_rate_ff;
  logic [2:0]  cp_fmt_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;

  rate_tick_if dp_tk ();
  rate_tick_if cp_tk ();

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Select registers only store; nothing downstream sees them until apply
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_ff         <= serial_cfg_pkg::RST_COMMAND;
      dp_rate_sel_ff <= serial_cfg_pkg::RST_DP_RATE_SELECT;
      dp_par_sel_ff  <= serial_cfg_pkg::RST_DP_PARITY_SELECT;
      cp_rate_sel_ff <= serial_cfg_pkg::RST_CP_RATE_SELECT;
      cp_fmt_sel_ff  <= serial_cfg_pkg::RST_CP_FRAME_FORMAT;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        serial_cfg_pkg::OFS_COMMAND:          cmd_ff         <= reg_wdata_in;
        serial_cfg_pkg::OFS_DP_RATE_SELECT:   dp_rate_sel_ff <= reg_wdata_in;
        serial_cfg_pkg::OFS_DP_PARITY_SELECT: dp_par_sel_ff  <= reg_wdata_in;
        serial_cfg_pkg::OFS_CP_RATE_SELECT:   cp_rate_sel_ff <= reg_wdata_in;
        serial_cfg_pkg::OFS_CP_FRAME_FORMAT:  cp_fmt_sel_ff  <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Module reset / apply
  // ==========================================================================
  // Pending flag loads the defaults on the first edge after reset release
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      apply_pend_ff <= 1'b1;
    end else begin
      apply_pend_ff <= 1'b0;
    end
  end

  assign apply = apply_pend_ff
               | (reg_wr_in && reg_addr_in == serial_cfg_pkg::OFS_COMMAND
                  && reg_wdata_in == serial_cfg_pkg::CMD_MODULE_RESET);

  // ==========================================================================
  // Data port format
  // ==========================================================================
  // No-parity trades the parity slot for a second stop bit
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dp_par_en_ff   <= 1'b1;
      dp_odd_ff      <= 1'b0;
      dp_two_stop_ff <= 1'b0;
    end else if (apply) begin
      unique case (dp_par_sel_ff)
        serial_cfg_pkg::DP_PAR_ODD: begin
          dp_par_en_ff   <= 1'b1;
          dp_odd_ff      <= 1'b1;
          dp_two_stop_ff <= 1'b0;
        end
        serial_cfg_pkg::DP_PAR_NONE: begin
          dp_par_en_ff   <= 1'b0;
          dp_odd_ff      <= 1'b0;
          dp_two_stop_ff <= 1'b1;
        end
        default: begin
          // Even parity, also the fallback for an invalid code
          dp_par_en_ff   <= 1'b1;
          dp_odd_ff      <= 1'b0;
          dp_two_stop_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Data port rate and auto detection
  // ==========================================================================
  // Hunt walks 1..7 and wraps; each bad frame moves one rate on
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dp_rate_ff   <= serial_cfg_pkg::RATE_FIRST;
      dp_auto_ff   <= 1'b1;
      dp_locked_ff <= 1'b0;
    end else if (apply) begin
      if (dp_rate_sel_ff == 16'h0000) begin
        dp_rate_ff   <= serial_cfg_pkg::RATE_FIRST;
        dp_auto_ff   <= 1'b1;
        dp_locked_ff <= 1'b0;
      end else if (dp_rate_sel_ff > 16'h0007) begin
        dp_rate_ff   <= serial_cfg_pkg::RATE_DEFAULT;
        dp_auto_ff   <= 1'b0;
        dp_locked_ff <= 1'b1;
      end else begin
        dp_rate_ff   <= dp_rate_sel_ff[2:0];
        dp_auto_ff   <= 1'b0;
        dp_locked_ff <= 1'b1;
      end
    end else if (dp_auto_ff && !dp_locked_ff) begin
      if (dp_frame_ok_in) begin
        dp_locked_ff <= 1'b1;
      end else if (dp_frame_bad_in) begin
        dp_rate_ff <= (dp_rate_ff == serial_cfg_pkg::RATE_LAST) ?
                      serial_cfg_pkg::RATE_FIRST : dp_rate_ff + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Config port rate and format
  // ==========================================================================
  // Fixed rate only; code 0 is treated as invalid, never as auto
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cp_rate_ff <= serial_cfg_pkg::RATE_DEFAULT;
      cp_fmt_ff  <= serial_cfg_pkg::FMT_DEFAULT;
    end else if (apply) begin
      if (cp_rate_sel_ff == 16'h0000 || cp_rate_sel_ff > 16'h0007) begin
        cp_rate_ff <= serial_cfg_pkg::RATE_DEFAULT;
      end else begin
        cp_rate_ff <= cp_rate_sel_ff[2:0];
      end
      if (cp_fmt_sel_ff > serial_cfg_pkg::FMT_MAX) begin
        cp_fmt_ff <= serial_cfg_pkg::FMT_DEFAULT;
      end else begin
        cp_fmt_ff <= cp_fmt_sel_ff[2:0];
      end
    end
  end

  // ==========================================================================
  // Tick generators
  // ==========================================================================
  assign dp_tk.rate_code = dp_rate_ff;
  assign cp_tk.rate_code = cp_rate_ff;

  baud_tick_gen #(.CLK_HZ(CLK_HZ)) u_dp_tick (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .tk          (dp_tk.gen)
  );

  baud_tick_gen #(.CLK_HZ(CLK_HZ)) u_cp_tick (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .tk          (cp_tk.gen)
  );

  // ==========================================================================
  // Port outputs
  // ==========================================================================
  // Config port odd select is masked so it cannot leak out while parity is off
  assign dp_bit_tick_out   = dp_tk.tick;
  assign dp_parity_en_out  = dp_par_en_ff;
  assign dp_odd_parity_out = dp_odd_ff;
  assign dp_two_stop_out   = dp_two_stop_ff;
  assign dp_reply_en_out   = dp_locked_ff;
  assign cp_bit_tick_out   = cp_tk.tick;
  assign cp_parity_en_out  = cp_fmt_ff[serial_cfg_pkg::FMT_PARITY_ENABLE_BIT];
  assign cp_odd_parity_out = cp_fmt_ff[serial_cfg_pkg::FMT_ODD_PARITY_BIT]
                           & cp_fmt_ff[serial_cfg_pkg::FMT_PARITY_ENABLE_BIT];
  assign cp_two_stop_out   = cp_fmt_ff[serial_cfg_pkg::FMT_TWO_STOP_BITS_BIT];

  // ==========================================================================
  // Register reads
  // ==========================================================================
  // Status reads show active settings, not the pending selections
  always_comb begin
    unique case (reg_addr_in)
      serial_cfg_pkg::OFS_COMMAND:          nxt_rdata = cmd_ff;
      serial_cfg_pkg::OFS_DP_RATE_SELECT:   nxt_rdata = dp_rate_sel_ff;
      serial_cfg_pkg::OFS_DP_PARITY_SELECT: nxt_rdata = dp_par_sel_ff;
      serial_cfg_pkg::OFS_DP_RATE_STATUS:
        nxt_rdata = dp_locked_ff ? {13'h0000, dp_rate_ff} : 16'h0000;
      serial_cfg_pkg::OFS_CP_RATE_SELECT:   nxt_rdata = cp_rate_sel_ff;
      serial_cfg_pkg::OFS_CP_FRAME_FORMAT:  nxt_rdata = cp_fmt_sel_ff;
      serial_cfg_pkg::OFS_CP_RATE_STATUS:   nxt_rdata = {13'h0000, cp_rate_ff};
      serial_cfg_pkg::OFS_CP_FORMAT_STATUS: nxt_rdata = {13'h0000, cp_fmt_ff};
      default:                              nxt_rdata = 16'h0000;
    endcase
  end

  // Read data is held until the next read strobe
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_hunting;
    dp_auto_ff && !dp_locked_ff && !apply;
  endsequence

  sequence s_bad_frame_at_3;
    s_hunting ##0 (dp_frame_bad_in && !dp_frame_ok_in && dp_rate_ff == 3'h3);
  endsequence

  a_dp_odd_code: assert property (apply && dp_par_sel_ff == 16'h0001 |=>
    dp_parity_en_out && dp_odd_parity_out && !dp_two_stop_out)
    else $error("data port odd code not applied");

  a_dp_frame_len: assert property (dp_parity_en_out != dp_two_stop_out)
    else $error("data port frame length changed");

  // Back-to-back command writes are legal, so the hold window skips that case
  a_hold_till_reset: assert property (reg_wr_in && !apply
    && reg_addr_in == 16'h0012 ##1 !apply |-> $stable(cp_rate_ff) [*2])
    else $error("config rate changed without reset");

  a_dp_status_zero: assert property (reg_rd_in && !dp_locked_ff
    && reg_addr_in == 16'h0007 |=> reg_rdata_out == 16'h0000)
    else $error("unlocked data rate status not zero");

  a_cp_rate_apply: assert property (apply && cp_rate_sel_ff >= 16'h0001
    && cp_rate_sel_ff <= 16'h0007 |=> cp_rate_ff == $past(cp_rate_sel_ff[2:0]))
    else $error("config rate not applied");

  a_cp_no_auto: assert property (cp_rate_ff != 3'h0)
    else $error("config port rate code zero");

  a_bad_fallback: assert property (apply && cp_rate_sel_ff == 16'h0000
    |=> cp_rate_ff == 3'h7)
    else $error("invalid config rate did not fall back");

  a_odd_masked: assert property (!cp_parity_en_out |-> !cp_odd_parity_out)
    else $error("odd parity with parity disabled");

  a_hunt_step: assert property (s_bad_frame_at_3 |=> dp_rate_ff == 3'h4
    ##0 !dp_reply_en_out)
    else $error("auto detect did not step rate");

  a_cp_rate_read: assert property (reg_rd_in && !apply
    && reg_addr_in == 16'h0014 |=> reg_rdata_out == {13'h0000, cp_rate_ff})
    else $error("config rate status wrong");

endmodule

/* verification/frame_source.sv */
// Stand-in for the data port frame decoder behind the polling master.
// Assumes poll() is called just after a rising edge of core_clk_in.
`timescale 1ns/1ps
module frame_source (
  input  wire logic core_clk_in,     // Core clock
  output logic      frame_ok_out,    // Good frame pulse
  output logic      frame_bad_out    // Bad frame pulse
);
  // ==========================================================================
  // Poll outcomes
  // ==========================================================================
  // Idle low; a wrong rate shows up as a bad frame, not as silence
  initial begin
    frame_ok_out  = 1'b0;
    frame_bad_out = 1'b0;
  end

  // One pulse per poll, then a quiet cycle so two polls never merge
  task automatic poll(input logic good);
    frame_ok_out  = good;
    frame_bad_out = !good;
    @(posedge core_clk_in);
    #1;
    frame_ok_out  = 1'b0;
    frame_bad_out = 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask
endmodule

/* verification/serial_port_config_tb.sv */
// Self-checking bench: register access, settings applied by module reset,
// frame format decoding, bit tick periods and the data port rate hunt.
// Assumes frame_source stands in for the data port frame decoder.
`timescale 1ns/1ps
module serial_port_config_tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int CLK_HZ = 1152000;   // Short periods: 10 cycles at 115200
  logic        core_clk_in;
  logic        reset_n_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic [15:0] reg_rdata_out;
  logic        ok_w;
  logic        bad_w;
  logic        dp_tick;
  logic        dp_par;
  logic        dp_odd;
  logic        dp_two;
  logic        dp_reply;
  logic        cp_tick;
  logic        cp_par;
  logic        cp_odd;
  logic        cp_two;
  int          error_cnt;
  int          check_count;
  int          bauds [7] = '{serial_cfg_pkg::BAUD_2400, serial_cfg_pkg::BAUD_4800,
    serial_cfg_pkg::BAUD_9600, serial_cfg_pkg::BAUD_19200, serial_cfg_pkg::BAUD_38400,
    serial_cfg_pkg::BAUD_57600, serial_cfg_pkg::BAUD_115200};
  `define CHK(n, e, g) chk(n, 16'(e), 16'(g))

  serial_port_config #(.CLK_HZ(CLK_HZ)) DUT (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .dp_frame_ok_in(ok_w), .dp_frame_bad_in(bad_w), .dp_bit_tick_out(dp_tick),
    .dp_parity_en_out(dp_par), .dp_odd_parity_out(dp_odd), .dp_two_stop_out(dp_two),
    .dp_reply_en_out(dp_reply), .cp_bit_tick_out(cp_tick), .cp_parity_en_out(cp_par),
    .cp_odd_parity_out(cp_odd), .cp_two_stop_out(cp_two));
  frame_source src (.core_clk_in(core_clk_in), .frame_ok_out(ok_w), .frame_bad_out(bad_w));

  // 200 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Each access starts one edge later, so strobes never toggle twice at once
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    #1;
    reg_wr_in    = 1'b1;
    reg_addr_in  = a;
    reg_wdata_in = d;
    @(posedge core_clk_in);
    #1;
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    #1;
    reg_rd_in   = 1'b1;
    reg_addr_in = a;
    @(posedge core_clk_in);
    #1;
    reg_rd_in = 1'b0;
    `CHK("rdata", e, reg_rdata_out);
  endtask

  task automatic apply();
    wr(serial_cfg_pkg::OFS_COMMAND, serial_cfg_pkg::CMD_MODULE_RESET);
  endtask

  // Cycles between two ticks; bounded so a dead generator cannot hang the run
  task automatic tick_gap(input bit dp, input int exp);
    int n;
    int seen;
    n    = 0;
    seen = 0;
    for (int i = 0; i < 1200 && seen < 2; i++) begin
      @(posedge core_clk_in);
      #1;
      if (seen == 1) n++;
      if ((dp ? dp_tick : cp_tick) === 1'b1) seen++;
    end
    if (seen < 2) begin
      error_cnt++;
      $display("ERROR tick count expected 2 seen %0d", seen);
      close_out();
    end else begin
      `CHK("tick gap", exp, n);
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    error_cnt   = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    rd(serial_cfg_pkg::OFS_DP_RATE_SELECT, 16'h0000);
    rd(serial_cfg_pkg::OFS_DP_PARITY_SELECT, 16'h0000);
    rd(serial_cfg_pkg::OFS_CP_FRAME_FORMAT, 16'h0001);
    rd(serial_cfg_pkg::OFS_CP_FORMAT_STATUS, 16'h0001);
    rd(16'h0030, 16'h0000);
    wr(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0002);
    rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0007);
    // New settings stay dormant until the command write
    wr(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'h0003);
    rd(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'h0003);
    tick_gap(1'b0, CLK_HZ / serial_cfg_pkg::BAUD_115200);
    // Only the reset code applies; any other command leaves the rate alone
    wr(serial_cfg_pkg::OFS_COMMAND, 16'h0000);
    rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0007);
    for (int c = 1; c <= 7; c++) begin
      wr(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'(c));
      apply();
      rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'(c));
      tick_gap(1'b0, CLK_HZ / bauds[c - 1]);
    end
    // Rate 0 is no auto request on this port: falls back to the top rate
    wr(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'h0000);
    apply();
    rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0007);
    tick_gap(1'b0, CLK_HZ / serial_cfg_pkg::BAUD_115200);
    // Out of range code must pull a slow rate back to the top rate
    wr(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'h0002);
    apply();
    wr(serial_cfg_pkg::OFS_CP_RATE_SELECT, 16'h0008);
    apply();
    rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0007);
    for (int f = 0; f < 9; f++) begin
      wr(serial_cfg_pkg::OFS_CP_FRAME_FORMAT, 16'(f));
      apply();
      rd(serial_cfg_pkg::OFS_CP_FORMAT_STATUS, 16'(f < 8 ? f : 1));
      `CHK("cp parity", f < 8 ? f[0] : 1, cp_par);
      `CHK("cp odd", f[0] & f[1], cp_odd);
      `CHK("cp stop", f[2], cp_two);
    end
    // Data port coding, code 3 is invalid and falls back to even parity
    for (int p = 0; p < 4; p++) begin
      wr(serial_cfg_pkg::OFS_DP_PARITY_SELECT, 16'(p));
      apply();
      `CHK("dp parity", p != 2, dp_par);
      `CHK("dp odd", p == 1, dp_odd);
      `CHK("dp bits", 1, 2'(dp_par) + 2'(dp_two));
    end
    // Hunt: nine bad polls step past the wrap to rate 3, then lock
    wr(serial_cfg_pkg::OFS_DP_RATE_SELECT, 16'h0000);
    apply();
    rd(serial_cfg_pkg::OFS_DP_RATE_STATUS, 16'h0000);
    for (int i = 0; i < 9; i++) src.poll(1'b0);
    `CHK("reply", 0, dp_reply);
    src.poll(1'b1);
    `CHK("reply", 1, dp_reply);
    rd(serial_cfg_pkg::OFS_DP_RATE_STATUS, 16'h0003);
    tick_gap(1'b1, CLK_HZ / serial_cfg_pkg::BAUD_9600);
    wr(serial_cfg_pkg::OFS_DP_RATE_SELECT, 16'h0006);
    apply();
    `CHK("reply", 1, dp_reply);
    rd(serial_cfg_pkg::OFS_DP_RATE_STATUS, 16'h0006);
    tick_gap(1'b1, CLK_HZ / serial_cfg_pkg::BAUD_57600);
    // Out of range data rate is fixed at the top rate, not hunted
    wr(serial_cfg_pkg::OFS_DP_RATE_SELECT, 16'h0009);
    apply();
    rd(serial_cfg_pkg::OFS_DP_RATE_STATUS, 16'h0007);
    tick_gap(1'b1, CLK_HZ / serial_cfg_pkg::BAUD_115200);
    // A second reset brings back the defaults
    reset_n_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    rd(serial_cfg_pkg::OFS_CP_RATE_STATUS, 16'h0007);
    rd(serial_cfg_pkg::OFS_DP_RATE_STATUS, 16'h0000);
    `CHK("reply", 0, dp_reply);
    close_out();
  end
endmodule
